/* rtl/csc_channel.sv */
// Chosen here: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
// Function
// R1 - mode field 00 clocked, 01 async, 10 two-wire; 11 forbidden
// R2 - interrupt source bit: 0 transfer end, 1 buffer empty
// R3 - transmit and receive enable bits gate communication
// R4 - phase and polarity bits pick one of four clock types; in slave mode the phase bit is ignored
// R5 - bit order bit: 0 msb first, 1 lsb first, both ways
// R6 - length field 11 eight bits, 10 seven, 00 nine async, 01 banned
// R7 - divider N in data bits 15..9 gives clock / (N+1)*2
// R8 - clock output pin follows clock level bit when idle
// R9 - data output pin follows data level bit when not shifting
// R10 - shifter drives data pin only when output enable set
// R11 - port latch drives pin in output mode, reads pin in input
// R12 - clock source bit picks divided clock or external clock pin
// R13 - four-bit prescaler divides system clock by power of two
// R14 - master moves one bit out and in per clock period
module csc_channel (
  // clock and reset
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  // wishbone slave
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [5:0]          wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [31:0]         wb_dat_i,
  output logic      [31:0]         wb_dat_o,
  output logic                     wb_ack_o,
  // serial pins
  input  wire logic                sck_i,
  input  wire logic                si_i,
  output csc_pkg::csc_serial_t     ser_o,
  // port one pins
  input  wire logic [7:0]          port_i,
  output logic      [7:0]          port_o,
  output logic      [7:0]          port_oe_n_o,
  // interrupt
  output logic                     irq_o
);
  import csc_pkg::*;

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic [15:0] mode_reg, comm_reg, levels_reg, enables_reg;
  logic [6:0]  div_reg, div_cnt_reg;
  logic [8:0]  txd_reg, rxd_reg;
  logic [7:0]  port_reg, dir_reg, tx_sh_reg, rx_sh_reg;
  logic [7:0]  pin_s1_reg, pin_s2_reg, rx_next;
  logic [3:0]  psel_reg;
  logic [14:0] pre_cnt_reg;
  logic [4:0]  half_reg, last_half;
  logic [1:0]  sts_reg, msk_reg, sts_set;
  logic        sck_s1_reg, sck_s2_reg, sck_s3_reg;
  logic        si_s1_reg, si_s2_reg, len7_reg;
  logic        req, wr, start, done, mck_tick, half_evt;
  logic        sample, slave, dap, tx_bit, sck_gen, len_ok;
  logic [15:0] wmode, wcomm;
  logic [31:0] rd_next;
  csc_state_t  state_reg;
  csc_serial_t ser_next;

  // byte-lane merge of a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old,
    input logic [31:0] d, input logic [3:0] sel);
    merge16 = {sel[1] ? d[15:8] : old[15:8],
               sel[0] ? d[7:0] : old[7:0]};
  endfunction : merge16

  // prescaler mask for a power-of-two division
  function automatic logic [14:0] pmask(input logic [3:0] sel);
    pmask = 15'((32'h0000_0001 << sel) - 32'h0000_0001);
  endfunction : pmask

  // ---------------------------------------------------------------
  // wishbone decode
  // ---------------------------------------------------------------
  assign req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr    = req & wb_we_i;
  assign wmode = merge16(mode_reg, wb_dat_i, wb_sel_i);
  assign wcomm = merge16(comm_reg, wb_dat_i, wb_sel_i);

  // ack comes one cycle after the request, and drops after one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= rd_next;
    end
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    rd_next = 32'h0000_0000;
    case (wb_adr_i)
      OFS_MODE:     rd_next[15:0] = mode_reg;
      OFS_COMM:     rd_next[15:0] = comm_reg;
      OFS_DATA:     rd_next[15:0] = {div_reg, rxd_reg};
      OFS_LEVELS:   rd_next[15:0] = levels_reg;
      OFS_ENABLES:  rd_next[15:0] = enables_reg;
      // input-mode bits show the pin, output-mode bits the latch
      OFS_PORT:     rd_next[7:0]  = (dir_reg & pin_s2_reg) |
                                    (~dir_reg & port_reg); // R11
      OFS_PORT_DIR: rd_next[7:0]  = dir_reg;
      OFS_PRESCALE: rd_next[3:0]  = psel_reg;
      OFS_STATUS: begin
        rd_next[1:0]   = sts_reg;
        rd_next[ST_BUSY] = (state_reg == ST_SHIFT);
      end
      OFS_MASK:     rd_next[1:0]  = msk_reg;
      default:      rd_next = 32'h0000_0000;
    endcase
  end

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_reg    <= RST_MODE;
      comm_reg    <= RST_COMM;
      levels_reg  <= RST_LEVELS;
      enables_reg <= RST_ZERO;
      div_reg     <= 7'h00;
      txd_reg     <= 9'h000;
      port_reg    <= 8'h00;
      dir_reg     <= RST_DIR;
      psel_reg    <= 4'h0;
      msk_reg     <= 2'h0;
    end else if (wr) begin
      case (wb_adr_i)
        OFS_MODE:     mode_reg    <= wmode;
        OFS_COMM:     comm_reg    <= wcomm;
        OFS_LEVELS:   levels_reg  <= merge16(levels_reg, wb_dat_i,
                                             wb_sel_i);
        OFS_ENABLES:  enables_reg <= merge16(enables_reg, wb_dat_i,
                                             wb_sel_i);
        OFS_DATA: begin
          if (wb_sel_i[1]) div_reg <= wb_dat_i[DIV_HI:DIV_LO]; // R7
          if (wb_sel_i[0]) txd_reg[7:0] <= wb_dat_i[7:0];
          if (wb_sel_i[1]) txd_reg[8] <= wb_dat_i[8];
        end
        OFS_PORT:     if (wb_sel_i[0]) port_reg <= wb_dat_i[7:0];
        OFS_PORT_DIR: if (wb_sel_i[0]) dir_reg <= wb_dat_i[7:0];
        OFS_PRESCALE: if (wb_sel_i[0]) psel_reg <= wb_dat_i[3:0];
        OFS_MASK:     if (wb_sel_i[0]) msk_reg <= wb_dat_i[1:0];
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {sck_s1_reg, sck_s2_reg, sck_s3_reg} <= 3'h7;
      {si_s1_reg, si_s2_reg} <= 2'h0;
      pin_s1_reg <= 8'h00;
      pin_s2_reg <= 8'h00;
    end else begin
      sck_s1_reg <= sck_i;
      sck_s2_reg <= sck_s1_reg;
      sck_s3_reg <= sck_s2_reg; // edge history, reads stage two only
      si_s1_reg  <= si_i;
      si_s2_reg  <= si_s1_reg;
      pin_s1_reg <= port_i;
      pin_s2_reg <= pin_s1_reg;
    end
  end

  // ---------------------------------------------------------------
  // operation clock prescaler and transfer divider
  // ---------------------------------------------------------------
  // free-running count; a tick when the selected low bits are all ones
  always_ff @(posedge clk_i) begin
    if (rst_i) pre_cnt_reg <= 15'h0000;
    else       pre_cnt_reg <= pre_cnt_reg + 15'h0001;
  end
  assign mck_tick = (pre_cnt_reg & pmask(psel_reg)) ==
                    pmask(psel_reg); // R13

  assign slave = mode_reg[CLK_SRC];
  // slave edges come from the synchronised pin, so the shift clock is
  // limited to well under a quarter of the system clock
  assign half_evt = (state_reg == ST_SHIFT) &&
                    (slave ? (sck_s2_reg ^ sck_s3_reg) // R12
                           : (mck_tick && div_cnt_reg == div_reg));

  // one half period is N+1 operation clock ticks
  always_ff @(posedge clk_i) begin
    if (rst_i || state_reg != ST_SHIFT) div_cnt_reg <= 7'h00;
    else if (mck_tick)
      div_cnt_reg <= (div_cnt_reg == div_reg) ? 7'h00 :
                     div_cnt_reg + 7'h01; // R7
  end

  // ---------------------------------------------------------------
  // frame control
  // ---------------------------------------------------------------
  assign len_ok = comm_reg[LEN_HI:LEN_LO] == LEN_8 ||
                  comm_reg[LEN_HI:LEN_LO] == LEN_7; // R6
  assign start  = wr && wb_adr_i == OFS_DATA && wb_sel_i[0] &&
                  state_reg == ST_IDLE &&
                  mode_reg[MODE_HI:MODE_LO] == MODE_CSI && len_ok &&
                  (comm_reg[TX_EN] | comm_reg[RX_EN]); // R1 R3
  assign dap       = comm_reg[PHASE] & ~slave;
  assign last_half = (len7_reg ? 5'd13 : 5'd15) + {4'h0, dap};
  assign done      = half_evt && half_reg == last_half;
  // sample at even halves, skipping the leading half of late phase
  assign sample    = half_evt && !half_reg[0] &&
                     !(dap && half_reg == 5'd0); // R4
  assign sck_gen   = half_reg[0] ^ dap ^ comm_reg[POLARITY]; // R4
  assign tx_bit    = comm_reg[ORDER] ? tx_sh_reg[0] :
                     (len7_reg ? tx_sh_reg[6] : tx_sh_reg[7]); // R5

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= ST_IDLE;
      half_reg  <= 5'd0;
      len7_reg  <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: if (start) begin
          state_reg <= ST_SHIFT;
          half_reg  <= 5'd0;
          len7_reg  <= comm_reg[LEN_HI:LEN_LO] == LEN_7; // R6
        end
        ST_SHIFT: if (done) state_reg <= ST_IDLE;
                  else if (half_evt) half_reg <= half_reg + 5'd1; // R14
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // shift registers
  // ---------------------------------------------------------------
  assign rx_next = comm_reg[ORDER] ? {si_s2_reg, rx_sh_reg[7:1]}
                                   : {rx_sh_reg[6:0], si_s2_reg}; // R5

  // transmit moves on at the end of each odd half period; the load takes
  // the bus word, since the data register only lands on this same edge
  always_ff @(posedge clk_i) begin
    if (rst_i) tx_sh_reg <= 8'h00;
    else if (start) tx_sh_reg <= wb_dat_i[7:0];
    else if (half_evt && half_reg[0])
      tx_sh_reg <= comm_reg[ORDER] ? tx_sh_reg >> 1
                                   : tx_sh_reg << 1; // R14
  end

  // received data is held when reception is disabled; the shifter still samples
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_sh_reg <= 8'h00;
      rxd_reg   <= 9'h000;
    end else begin
      if (sample) rx_sh_reg <= rx_next; // R14
      if (done && comm_reg[RX_EN]) begin // R3
        if (!len7_reg) rxd_reg <= {1'b0, sample ? rx_next : rx_sh_reg};
        else if (comm_reg[ORDER])
          rxd_reg <= {2'h0, sample ? rx_next[7:1] : rx_sh_reg[7:1]};
        else
          rxd_reg <= {2'h0, sample ? rx_next[6:0] : rx_sh_reg[6:0]};
      end
    end
  end

  // ---------------------------------------------------------------
  // interrupt status and mask
  // ---------------------------------------------------------------
  // setup error: forbidden mode, or any length but eight or seven bits, written
  assign sts_set[ST_ERR] = wr &&
    ((wb_adr_i == OFS_MODE && wmode[MODE_HI:MODE_LO] == MODE_BAD) ||
     (wb_adr_i == OFS_COMM && wcomm[LEN_HI:LEN_LO] != LEN_8 &&
      wcomm[LEN_HI:LEN_LO] != LEN_7)); // R1 R6
  assign sts_set[ST_CHAN] = mode_reg[IRQ_SRC] ? start : done; // R2

  // set wins over a write-one clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) sts_reg <= 2'h0;
    else sts_reg <= (sts_reg & ~((wr && wb_adr_i == OFS_STATUS &&
                     wb_sel_i[0]) ? wb_dat_i[1:0] : 2'h0)) | sts_set;
  end

  // ---------------------------------------------------------------
  // pin outputs
  // ---------------------------------------------------------------
  always_comb begin
    ser_next.so = (state_reg == ST_SHIFT && comm_reg[TX_EN] &&
                   enables_reg[SOE_BIT]) ? tx_bit
                                         : levels_reg[SO_BIT]; // R9 R10
    ser_next.sck = (state_reg == ST_SHIFT && !slave) ? sck_gen
                                         : levels_reg[CKO_BIT]; // R8
    ser_next.sck_oe_n = slave; // R12
  end

  // every pin output is registered
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ser_o       <= '{sck: 1'b1, sck_oe_n: 1'b0, so: 1'b1};
      port_o      <= 8'h00;
      port_oe_n_o <= RST_DIR;
      irq_o       <= 1'b0;
    end else begin
      ser_o       <= ser_next;
      port_o      <= port_reg; // R11
      port_oe_n_o <= dir_reg; // R11
      irq_o       <= |(sts_reg & msk_reg);
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_mode_gate: assert property (@(posedge clk_i) disable iff (rst_i) // R1
    $rose(state_reg == ST_SHIFT) |->
      $past(mode_reg[MODE_HI:MODE_LO]) == MODE_CSI)
    else $error("frame started outside clocked mode");
  a_irq_source: assert property (@(posedge clk_i) disable iff (rst_i) // R2
    (done && !mode_reg[IRQ_SRC]) |=> sts_reg[ST_CHAN])
    else $error("transfer end did not raise status");
  a_rx_hold: assert property (@(posedge clk_i) disable iff (rst_i) // R3
    !comm_reg[RX_EN] |=> $stable(rxd_reg))
    else $error("receive data changed while reception off");
  a_len_legal: assert property (@(posedge clk_i) disable iff (rst_i) // R6
    $rose(state_reg == ST_SHIFT) |-> $past(comm_reg[LEN_HI]))
    else $error("frame started with illegal length");
  a_div_bound: assert property (@(posedge clk_i) disable iff (rst_i) // R7
    (state_reg == ST_SHIFT && !slave && $stable(div_reg)) |->
      div_cnt_reg <= div_reg)
    else $error("divider count ran past its limit");
  a_idle_sck: assert property (@(posedge clk_i) disable iff (rst_i) // R8
    (state_reg == ST_IDLE) ##1 (state_reg == ST_IDLE) |->
      ser_o.sck == $past(levels_reg[CKO_BIT]))
    else $error("idle clock pin not at level bit");
  a_so_stop: assert property (@(posedge clk_i) disable iff (rst_i) // R10
    !enables_reg[SOE_BIT] |=> ser_o.so == $past(levels_reg[SO_BIT]))
    else $error("data pin driven while output stopped");
  a_port_dir: assert property (@(posedge clk_i) disable iff (rst_i) // R11
    ##1 port_oe_n_o == $past(dir_reg) && port_o == $past(port_reg))
    else $error("port pins do not follow latch");
  a_slave_oe: assert property (@(posedge clk_i) disable iff (rst_i) // R12
    slave ##1 slave |-> ser_o.sck_oe_n)
    else $error("clock pin driven in slave mode");
  a_presc_one: assert property (@(posedge clk_i) disable iff (rst_i) // R13
    psel_reg == 4'h0 |-> mck_tick)
    else $error("undivided prescaler missed a tick");
endmodule : csc_channel

/* rtl/csc_pkg.sv */
package csc_pkg;
  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [5:0] OFS_MODE     = 6'h00;
  localparam logic [5:0] OFS_COMM     = 6'h04;
  localparam logic [5:0] OFS_DATA     = 6'h08;
  localparam logic [5:0] OFS_LEVELS   = 6'h0C;
  localparam logic [5:0] OFS_ENABLES  = 6'h10;
  localparam logic [5:0] OFS_PORT     = 6'h14;
  localparam logic [5:0] OFS_PORT_DIR = 6'h18;
  localparam logic [5:0] OFS_PRESCALE = 6'h1C;
  localparam logic [5:0] OFS_STATUS   = 6'h20;
  localparam logic [5:0] OFS_MASK     = 6'h24;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int MODE_HI  = 2;
  localparam int MODE_LO  = 1;
  localparam int IRQ_SRC  = 0;
  localparam int CLK_SRC  = 14;
  localparam int TX_EN    = 15;
  localparam int RX_EN    = 14;
  localparam int PHASE    = 13;
  localparam int POLARITY = 12;
  localparam int ORDER    = 7;
  localparam int LEN_HI   = 1;
  localparam int LEN_LO   = 0;
  localparam int DIV_HI   = 15;
  localparam int DIV_LO   = 9;
  localparam int CKO_BIT  = 8;
  localparam int SO_BIT   = 0;
  localparam int SOE_BIT  = 0;
  localparam int ST_CHAN  = 0;
  localparam int ST_ERR   = 1;
  localparam int ST_BUSY  = 15;
  // ---------------------------------------------------------------
  // encodings and reset values
  // ---------------------------------------------------------------
  localparam logic [1:0]  MODE_CSI   = 2'h0;
  localparam logic [1:0]  MODE_BAD   = 2'h3;
  localparam logic [1:0]  LEN_8      = 2'h3;
  localparam logic [1:0]  LEN_7      = 2'h2;
  localparam logic [15:0] RST_MODE   = 16'h0020;
  localparam logic [15:0] RST_COMM   = 16'h0007;
  localparam logic [15:0] RST_LEVELS = 16'h0101;
  localparam logic [15:0] RST_ZERO   = 16'h0000;
  localparam logic [7:0]  RST_DIR    = 8'hFF;
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic sck;
    logic sck_oe_n;
    logic so;
  } csc_serial_t;
  typedef enum {ST_IDLE, ST_SHIFT} csc_state_t;
endpackage : csc_pkg

/* verification/csc_eeprom_model.sv */
`timescale 1ns/1ps
// three-wire serial memory: in phase 0 it samples on the edge leaving
// the polarity level, in phase 1 on the edge entering it, and presents
// its next reply bit on the opposite edge
module csc_eeprom_model (
  // link pins
  input  wire logic       sck_i,
  input  wire logic       so_i,
  input  wire logic       sel_i,
  output logic            si_o,
  // frame setup from the bench
  input  wire logic       cpol_i,
  input  wire logic       cpha_i,
  input  wire logic       lsb_i,
  input  wire logic [3:0] len_i,
  input  wire logic [7:0] reply_i,
  // what was shifted in
  output logic [7:0]      cap_o,
  output int              taken_o
);
  int   ptr;
  logic last_lvl;
  function automatic int pos(input int k);
    return lsb_i ? k : int'(len_i) - 1 - k;
  endfunction : pos
  initial begin
    cap_o = 8'h00;
    taken_o = 0;
    ptr = -1;
    last_lvl = 1'b1;
  end
  // a new select starts a frame; phase 0 has its first bit ready at once
  always @(posedge sel_i) begin
    cap_o = 8'h00;
    taken_o = 0;
    ptr = cpha_i ? -1 : 0;
  end
  // no shift before the first sample, in either phase
  always @(sck_i) begin
    if (sel_i && sck_i === ~(cpol_i ^ cpha_i) &&
        taken_o < int'(len_i)) begin
      cap_o[pos(taken_o)] = so_i;
      taken_o++;
    end else if (sel_i && sck_i === (cpol_i ^ cpha_i) &&
                 taken_o > 0) begin
      ptr++;
    end
  end
  // released line shows the inverse of its last level, never a stale bit
  always @* begin
    if (sel_i && ptr >= 0 && ptr < int'(len_i)) begin
      si_o = reply_i[pos(ptr)];
      last_lvl = si_o;
    end else begin
      si_o = ~last_lvl;
    end
  end
endmodule : csc_eeprom_model

/* verification/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import csc_pkg::*;
  localparam int DIVN = 3;
  localparam int PER  = 2 * (DIVN + 1) * 2;
  logic clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack, irq, cpol, cpha, lsb;
  logic [5:0]  wb_adr;
  logic [3:0]  wb_sel, mlen;
  logic [31:0] wb_wdat, wb_rdat;
  logic [7:0]  port_o, port_oe_n, pins, reply, cap;
  csc_serial_t ser;
  logic        si, sck_q;
  int          failures, num_checks, taken, cyc_n, last_t, per;
  // pins resolve from the driver enables; undriven port pins read 0xa0
  assign pins = (port_oe_n & 8'hA0) | (~port_oe_n & port_o);
  csc_channel csc_channel_inst (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
    .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
    .sck_i(ser.sck_oe_n ? 1'b1 : ser.sck), .si_i(si), .ser_o(ser),
    .port_i(pins), .port_o(port_o), .port_oe_n_o(port_oe_n), .irq_o(irq));
  csc_eeprom_model csc_eeprom_model_inst (.sck_i(ser.sck), .so_i(ser.so),
    .sel_i(pins[2]), .si_o(si), .cpol_i(cpol), .cpha_i(cpha), .lsb_i(lsb),
    .len_i(mlen), .reply_i(reply), .cap_o(cap), .taken_o(taken));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // interval between shift clock edges that leave the polarity level
  always @(posedge clk_i) begin
    cyc_n++;
    if (ser.sck !== sck_q && ser.sck === ~cpol) begin
      if (last_t >= 0) per = cyc_n - last_t;
      last_t = cyc_n;
    end
    sck_q = ser.sck;
  end
  task automatic check(input string name, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic tally_and_finish();
    if (failures == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish
  // one classic cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [5:0] a,
                    input logic [15:0] d, output logic [31:0] q);
    int k;
    k = 0;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_wdat <= {16'h0000, d};
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack !== 1'b1 && k < 50);
    q = wb_rdat;
    if (k >= 50) failures++;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask : wb
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
    repeat (2) @(posedge clk_i);
  endtask : wr
  task automatic t_reset();
    logic [5:0]  a[6] = '{OFS_MODE, OFS_COMM, OFS_LEVELS, OFS_ENABLES,
                          OFS_PORT_DIR, 6'h3C};
    logic [15:0] e[6] = '{RST_MODE, RST_COMM, RST_LEVELS, RST_ZERO,
                          {8'h00, RST_DIR}, RST_ZERO};
    logic [31:0] q;
    foreach (a[i]) begin
      wb(1'b0, a[i], 16'h0000, q);
      check("reset register", q, {16'h0000, e[i]});
    end
    check("idle clock pin", ser.sck, 1'b1);
    check("idle data pin", ser.so, 1'b1);
  endtask : t_reset
  task automatic t_levels();
    wr(OFS_LEVELS, 16'h0000);
    check("clock pin low", ser.sck, 1'b0);
    check("data pin low", ser.so, 1'b0);
    wr(OFS_LEVELS, 16'h0100);
    check("clock pin high", ser.sck, 1'b1);
    check("data pin held", ser.so, 1'b0);
  endtask : t_levels
  task automatic t_port();
    logic [31:0] q;
    wr(OFS_PORT_DIR, 16'h00FB);
    wr(OFS_PORT, 16'h0004);
    check("port drive", port_oe_n, 8'hFB);
    check("select level", port_o[2], 1'b1);
    wb(1'b0, OFS_PORT, 16'h0000, q);
    check("port read", q, 32'h0000_00A4);
    wr(OFS_PORT, 16'h0000);
  endtask : t_port
  // one frame against the memory model, then judged from both sides
  task automatic t_frame(input logic [15:0] comm, input logic oe,
                         input logic [7:0] tx, input logic [7:0] rx);
    logic [31:0] q;
    logic [7:0]  m;
    int k;
    cpol = comm[POLARITY];
    cpha = comm[PHASE];
    lsb = comm[ORDER];
    mlen = comm[LEN_LO] ? 4'd8 : 4'd7;
    m = comm[LEN_LO] ? 8'hFF : 8'h7F;
    reply = rx;
    wr(OFS_COMM, comm);
    wr(OFS_LEVELS, {7'h00, ~comm[POLARITY], 8'h00});
    wr(OFS_ENABLES, {15'h0000, oe});
    wr(OFS_PORT, 16'h0004);
    last_t = -1;
    per = 0;
    wr(OFS_DATA, {7'(DIVN), 1'b0, tx});
    k = 0;
    do begin
      wb(1'b0, OFS_STATUS, 16'h0000, q);
      k++;
    end while (q[ST_BUSY] !== 1'b0 && k < 200);
    check("frame ended", q[ST_BUSY], 1'b0);
    wb(1'b0, OFS_STATUS, 16'h0000, q);
    check("end event", q[ST_CHAN], 1'b1);
    wb(1'b0, OFS_DATA, 16'h0000, q);
    check("divider readback", q[15:9], 7'(DIVN));
    check("received byte", q[7:0] & m, rx & m);
    check("sent byte", cap & m, (oe ? tx : 8'h00) & m);
    check("bits taken", taken, mlen);
    check("clock period", per, PER);
    wr(OFS_PORT, 16'h0000);
    wr(OFS_STATUS, 16'h0003);
  endtask : t_frame
  task automatic t_err_irq();
    logic [31:0] q;
    wr(OFS_MASK, 16'h0002);
    wr(OFS_MODE, 16'h0006);
    wr(OFS_DATA, 16'h00A5);
    wb(1'b0, OFS_STATUS, 16'h0000, q);
    check("forbidden mode", q[ST_ERR], 1'b1);
    check("no frame", q[ST_BUSY], 1'b0);
    check("irq raised", irq, 1'b1);
    wr(OFS_MASK, 16'h0000);
    check("irq masked", irq, 1'b0);
    wr(OFS_MASK, 16'h0002);
    wr(OFS_STATUS, 16'h0002);
    check("irq cleared", irq, 1'b0);
    wr(OFS_MODE, 16'h0000);
    wr(OFS_COMM, 16'h0003);
    wr(OFS_DATA, 16'h00A5);
    wb(1'b0, OFS_STATUS, 16'h0000, q);
    check("both disabled", q[ST_BUSY], 1'b0);
    wr(OFS_MODE, 16'h4000);
    check("clock pin released", ser.sck_oe_n, 1'b1);
    wr(OFS_MODE, 16'h0001);
    check("clock pin driven", ser.sck_oe_n, 1'b0);
    wr(OFS_STATUS, 16'h0003);
    wr(OFS_COMM, 16'h4003);
    wr(OFS_DATA, {7'(DIVN), 9'h000});
    wb(1'b0, OFS_STATUS, 16'h0000, q);
    check("buffer empty event", q[ST_CHAN], 1'b1);
    check("receive only runs", q[ST_BUSY], 1'b1);
  endtask : t_err_irq
  initial begin
    {wb_cyc, wb_stb, wb_we, cpol, cpha, lsb, sck_q} = '0;
    {wb_adr, wb_wdat, reply, mlen} = '0;
    wb_sel = 4'h3;
    {failures, num_checks, cyc_n, per} = '0;
    last_t = -1;
    rst_i = 1'b1;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_levels();
    t_port();
    wr(OFS_PRESCALE, 16'h0001);
    t_frame(16'hC003, 1'b1, 8'h5A, 8'hC3);
    t_frame(16'hD082, 1'b1, 8'h35, 8'h4E);
    t_frame(16'hE003, 1'b1, 8'hB1, 8'h2D);
    t_frame(16'hF082, 1'b1, 8'h63, 8'h19);
    t_frame(16'hC003, 1'b0, 8'hFF, 8'h96);
    t_err_irq();
    tally_and_finish();
  end
  initial begin
    #500_000;
    failures++;
    tally_and_finish();
  end
endmodule : tb_top
